//--- rps_pkg.sv
// constants shared by the receive lane and frame status block
// assumes a single receive clock at 25 MHz and a plain register port
package rps_pkg;

	// ---------------------------------------------------------------
	// lane and frame geometry
	// ---------------------------------------------------------------
	localparam int NUM_LANES = 20;
	localparam int LANE_ID_W = 5;
	localparam int SLOTS     = 4;
	localparam int CNT_W     = 4;
	localparam int CRC_W     = 32;
	localparam int BIP_W     = 8;
	localparam int MAXLEN_W  = 15;
	localparam int BYTES_W   = 7;
	localparam int LEN_W     = 16;

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_MAX_LEN    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LIVE       = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_BER_COUNT  = 8'h10;
	localparam logic [MAXLEN_W-1:0] MAX_LEN_RST  = 15'h2580;

	// live status bit positions
	localparam int LIVE_HI_BER  = 0;
	localparam int LIVE_INT_LF  = 1;
	localparam int LIVE_RCV_LF  = 2;
	localparam int LIVE_ALIGNED = 3;
	localparam int LIVE_W       = 4;

	// interrupt status and mask bit positions
	localparam int IRQ_CRC     = 0;
	localparam int IRQ_INV_CRC = 1;
	localparam int IRQ_TRUNC   = 2;
	localparam int IRQ_BIP     = 3;
	localparam int IRQ_HI_BER  = 4;
	localparam int IRQ_INT_LF  = 5;
	localparam int IRQ_RCV_LF  = 6;
	localparam int IRQ_W       = 7;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 7'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int BER_WINDOW_NS  = 125000;
	localparam int BER_WIN_CYC    = BER_WINDOW_NS / CLK_PERIOD_NS;
	localparam int BER_WIN_W      = 12;
	localparam int BER_CNT_W      = 7;
	localparam logic [BER_CNT_W-1:0] BER_THRESHOLD = 7'h61;
	localparam logic [BER_WIN_W-1:0] BER_WIN_LAST  = BER_WIN_W'(BER_WIN_CYC - 1);

	// local fault sequence monitor
	localparam int LF_SEQ_W = 3;
	localparam int LF_COL_W = 7;
	localparam logic [LF_SEQ_W-1:0] LF_SEQ_TRIGGER = 3'h4;
	localparam logic [LF_COL_W-1:0] LF_COL_LAST    = 7'h7f;

	// fault monitor states, gray along idle, counting, fault
	typedef enum logic [1:0] {
		RPS_LF_IDLE  = 2'h0,
		RPS_LF_COUNT = 2'h1,
		RPS_LF_FAULT = 2'h3
	} rps_lf_state_t;

endpackage

//--- rps_fault_mon.sv
// received local fault monitor on the column stream
// assumes column qualifiers arrive on the receive clock
`timescale 1ns/1ps

module rps_fault_mon import rps_pkg::*; (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// column stream
	input  wire logic col_valid_in,
	input  wire logic col_lf_in,
	// fault level
	output logic      fault_out
);

	rps_lf_state_t         state_r, state_nxt;
	logic [LF_SEQ_W-1:0]   seq_r, seq_nxt;
	logic [LF_COL_W-1:0]   col_r, col_nxt;
	logic                  fault_r;

	// ---------------------------------------------------------------
	// sequence counting
	// ---------------------------------------------------------------
	// fault after enough fault columns, clear after a quiet window
	always_comb begin
		state_nxt = state_r;
		seq_nxt   = seq_r;
		col_nxt   = col_r;
		if (col_valid_in) begin
			case (state_r)
				RPS_LF_IDLE: begin
					if (col_lf_in) begin
						seq_nxt   = LF_SEQ_W'(1);
						col_nxt   = '0;
						state_nxt = RPS_LF_COUNT;
					end
				end
				RPS_LF_COUNT: begin
					if (col_lf_in) begin
						seq_nxt = seq_r + LF_SEQ_W'(1);
						col_nxt = '0;
						if (seq_nxt >= LF_SEQ_TRIGGER) begin
							state_nxt = RPS_LF_FAULT;
						end
					end else if (col_r == LF_COL_LAST) begin
						seq_nxt   = '0;
						state_nxt = RPS_LF_IDLE;
					end else begin
						col_nxt = col_r + LF_COL_W'(1);
					end
				end
				RPS_LF_FAULT: begin
					if (col_lf_in) begin
						col_nxt = '0;
					end else if (col_r == LF_COL_LAST) begin
						seq_nxt   = '0;
						state_nxt = RPS_LF_IDLE;
					end else begin
						col_nxt = col_r + LF_COL_W'(1);
					end
				end
				default: begin
					seq_nxt   = '0;
					col_nxt   = '0;
					state_nxt = RPS_LF_IDLE;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= RPS_LF_IDLE;
			seq_r   <= '0;
			col_r   <= '0;
			fault_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			seq_r   <= seq_nxt;
			col_r   <= col_nxt;
			fault_r <= (state_nxt == RPS_LF_FAULT);
		end
	end

	assign fault_out = fault_r;

endmodule

//--- rps_rx_status.sv
// receive lane map, frame error, bip, error rate and fault status
// assumes pcs inputs share the receive clock; test pattern enable is foreign
`timescale 1ns/1ps

// Behaviour
// - five-bit lane id per physical lane
// - id valid only while lane synchronised
// - marker-locked bit per demultiplexed pcs lane
// - per-cycle count of bad, non-inverted crcs
// - per-cycle count of inverted crcs
// - flag packet exceeding configured maximum length
// - frame error indicators pulse one cycle each
// - internal fault from pattern, alignment, error rate
// - received fault from partner fault sequence
// - bip8 error pulse per pcs lane
// - high error rate level at or above threshold
module rps_rx_status import rps_pkg::*; (
	// clock and reset
	input  wire logic                                CLK_IN,
	input  wire logic                                RST_N_IN,
	// register port
	input  wire logic [ADDR_W-1:0]                   REG_ADDR_IN,
	input  wire logic [DATA_W-1:0]                   REG_WDATA_IN,
	input  wire logic                                REG_WR_IN,
	input  wire logic                                REG_RD_IN,
	output logic      [DATA_W-1:0]                   REG_RDATA_OUT,
	output logic                                     IRQ_OUT,
	// lane markers per physical lane
	input  wire logic [NUM_LANES-1:0]                RX_LANE_SYNC_IN,
	input  wire logic [NUM_LANES-1:0]                MARKER_STB_IN,
	input  wire logic [NUM_LANES-1:0][LANE_ID_W-1:0] MARKER_ID_IN,
	output logic      [NUM_LANES-1:0][LANE_ID_W-1:0] RX_LANE_MAP_ID_OUT,
	output logic      [NUM_LANES-1:0]                RX_LANE_MARKER_LOCKED_OUT,
	// frame ends and length
	input  wire logic [SLOTS-1:0]                    EOP_SLOT_IN,
	input  wire logic [SLOTS-1:0][CRC_W-1:0]         CRC_CALC_IN,
	input  wire logic [SLOTS-1:0][CRC_W-1:0]         CRC_RCVD_IN,
	input  wire logic                                SOP_IN,
	input  wire logic [BYTES_W-1:0]                  BYTES_IN,
	output logic      [CNT_W-1:0]                    RX_CRC_ERROR_COUNT_OUT,
	output logic      [CNT_W-1:0]                    RX_INVERTED_CRC_COUNT_OUT,
	output logic                                     RX_TRUNCATED_OUT,
	// bip8 per pcs lane
	input  wire logic [NUM_LANES-1:0]                BIP_STB_IN,
	input  wire logic [NUM_LANES-1:0][BIP_W-1:0]     BIP_CALC_IN,
	input  wire logic [NUM_LANES-1:0][BIP_W-1:0]     BIP_RCVD_IN,
	output logic      [NUM_LANES-1:0]                RX_BIP_ERROR_OUT,
	// error rate and faults
	input  wire logic                                SH_VALID_IN,
	input  wire logic                                SH_ERROR_IN,
	input  wire logic                                ALIGNED_IN,
	input  wire logic                                TX_TEST_PATTERN_IN,
	input  wire logic                                COL_VALID_IN,
	input  wire logic                                COL_LOCAL_FAULT_IN,
	output logic                                     RX_ERROR_RATE_HIGH_OUT,
	output logic                                     RX_INTERNAL_FAULT_OUT,
	output logic                                     RX_RECEIVED_FAULT_OUT
);

	// ----------------
	// declarations
	// ----------------
	logic [NUM_LANES-1:0][LANE_ID_W-1:0] map_id_r;
	logic [NUM_LANES-1:0]                mapped_r;
	logic [NUM_LANES-1:0][NUM_LANES-1:0] lock_hit;
	logic [NUM_LANES-1:0]                lock_nxt;
	logic [NUM_LANES-1:0]                lock_r;
	logic [NUM_LANES-1:0]                bip_err;
	logic [NUM_LANES-1:0]                bip_r;
	logic [SLOTS-1:0]                    slot_bad;
	logic [SLOTS-1:0]                    slot_inv;
	logic [CNT_W-1:0]                    crc_cnt_r;
	logic [CNT_W-1:0]                    inv_cnt_r;
	logic [MAXLEN_W-1:0]                 max_len_r;
	logic                                in_pkt_r, in_pkt_nxt;
	logic                                trunc_done_r, trunc_done_nxt;
	logic [LEN_W-1:0]                    len_r, len_nxt;
	logic [LEN_W-1:0]                    len_base;
	logic                                trunc_hit;
	logic                                trunc_r;
	logic                                tpg_s1_r, tpg_s2_r, tpg_s3_r, tpg_r;
	logic [BER_WIN_W-1:0]                win_r, win_nxt;
	logic [BER_CNT_W-1:0]                ber_cnt_r, ber_cnt_nxt;
	logic [BER_CNT_W-1:0]                ber_last_r;
	logic                                win_end;
	logic                                hi_ber_r, hi_ber_nxt;
	logic                                int_lf_r, int_lf_nxt;
	logic                                rcv_lf;
	logic                                rcv_lf_d_r;
	logic [IRQ_W-1:0]                    irq_set;
	logic [IRQ_W-1:0]                    irq_st_r, irq_st_nxt;
	logic [IRQ_W-1:0]                    irq_mask_r;
	logic                                irq_r;
	logic [DATA_W-1:0]                   rdata_r, rdata_nxt;
	logic                                wr_max_len, wr_mask, rd_status;
	logic [LIVE_W-1:0]                   live;

	// count set bits of a slot vector
	function automatic logic [CNT_W-1:0] pop_slots(input logic [SLOTS-1:0] v);
		logic [CNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < SLOTS; i++) begin
			n = n + CNT_W'(v[i]);
		end
		return n;
	endfunction

	// ----------------
	// per physical lane mapping and per pcs lane checks
	// ----------------
	genvar g, h;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_lane
			// capture lane id on a marker while synchronised
			always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					map_id_r[g] <= '0;
					mapped_r[g] <= 1'b0;
				end else if (!RX_LANE_SYNC_IN[g]) begin
					mapped_r[g] <= 1'b0;
				end else if (MARKER_STB_IN[g]) begin
					map_id_r[g] <= MARKER_ID_IN[g];
					mapped_r[g] <= 1'b1;
				end
			end
			// physical lanes claiming pcs lane g
			for (h = 0; h < NUM_LANES; h++) begin : g_hit
				assign lock_hit[g][h] = mapped_r[h] && RX_LANE_SYNC_IN[h]
					&& (map_id_r[h] == LANE_ID_W'(g));
			end
			assign lock_nxt[g] = |lock_hit[g];
			// bip8 compare on each signature byte
			assign bip_err[g] = BIP_STB_IN[g] && (BIP_CALC_IN[g] != BIP_RCVD_IN[g]);
		end
		for (g = 0; g < SLOTS; g++) begin : g_slot
			// inverted crc is counted apart from a plain bad crc
			assign slot_inv[g] = EOP_SLOT_IN[g] && (CRC_RCVD_IN[g] == ~CRC_CALC_IN[g]);
			assign slot_bad[g] = EOP_SLOT_IN[g] && (CRC_RCVD_IN[g] != CRC_CALC_IN[g])
				&& !slot_inv[g];
		end
	endgenerate

	// lane lock and bip pulse registers
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			lock_r <= '0;
			bip_r  <= '0;
		end else begin
			lock_r <= lock_nxt;
			bip_r  <= bip_err;
		end
	end

	// ----------------
	// crc counts
	// ----------------
	// per-cycle counts, zero when no frame ends
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			crc_cnt_r <= '0;
			inv_cnt_r <= '0;
		end else begin
			crc_cnt_r <= pop_slots(slot_bad);
			inv_cnt_r <= pop_slots(slot_inv);
		end
	end

	// ----------------
	// length limit
	// ----------------
	// a start restarts the count, any frame end closes the packet
	assign len_base       = SOP_IN ? '0 : len_r;
	assign len_nxt        = (len_base == '1) ? len_base : len_base + LEN_W'(BYTES_IN);
	assign in_pkt_nxt     = SOP_IN || (in_pkt_r && !(|EOP_SLOT_IN));
	assign trunc_hit      = (SOP_IN || in_pkt_r) && !(trunc_done_r && !SOP_IN)
		&& (len_nxt > LEN_W'(max_len_r));
	assign trunc_done_nxt = trunc_hit || (trunc_done_r && !SOP_IN);

	// one pulse per packet that runs over
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			len_r        <= '0;
			in_pkt_r     <= 1'b0;
			trunc_done_r <= 1'b0;
			trunc_r      <= 1'b0;
		end else begin
			len_r        <= len_nxt;
			in_pkt_r     <= in_pkt_nxt;
			trunc_done_r <= trunc_done_nxt;
			trunc_r      <= trunc_hit;
		end
	end

	// ----------------
	// error rate monitor
	// ----------------
	// bad sync headers counted over a fixed window
	assign win_end     = (win_r == BER_WIN_LAST);
	assign win_nxt     = win_end ? '0 : win_r + BER_WIN_W'(1);
	always_comb begin
		ber_cnt_nxt = ber_cnt_r;
		if (SH_VALID_IN && SH_ERROR_IN && (ber_cnt_r != '1)) begin
			ber_cnt_nxt = ber_cnt_r + BER_CNT_W'(1);
		end
		if (win_end) begin
			ber_cnt_nxt = '0;
		end
	end
	// raise at threshold, re-judge at each window end
	assign hi_ber_nxt = win_end ? (ber_cnt_r >= BER_THRESHOLD)
		: (hi_ber_r || (ber_cnt_nxt >= BER_THRESHOLD));

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			win_r      <= '0;
			ber_cnt_r  <= '0;
			ber_last_r <= '0;
			hi_ber_r   <= 1'b0;
		end else begin
			win_r      <= win_nxt;
			ber_cnt_r  <= ber_cnt_nxt;
			ber_last_r <= win_end ? ber_cnt_r : ber_last_r;
			hi_ber_r   <= hi_ber_nxt;
		end
	end

	// ----------------
	// local faults
	// ----------------
	// test pattern enable comes from the transmit clock
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tpg_s1_r <= 1'b0;
			tpg_s2_r <= 1'b0;
			tpg_s3_r <= 1'b0;
			tpg_r    <= 1'b0;
		end else begin
			tpg_s1_r <= TX_TEST_PATTERN_IN;
			tpg_s2_r <= tpg_s1_r;
			tpg_s3_r <= tpg_s2_r;
			tpg_r    <= (tpg_s2_r == tpg_s3_r) ? tpg_s3_r : tpg_r;
		end
	end

	// internal fault holds while any cause lasts
	assign int_lf_nxt = tpg_r || !ALIGNED_IN || hi_ber_nxt;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			int_lf_r   <= 1'b0;
			rcv_lf_d_r <= 1'b0;
		end else begin
			int_lf_r   <= int_lf_nxt;
			rcv_lf_d_r <= rcv_lf;
		end
	end

	// partner fault sequence monitor
	rps_fault_mon u_fault_mon (
		.clk_in       (CLK_IN),
		.rst_n_in     (RST_N_IN),
		.col_valid_in (COL_VALID_IN),
		.col_lf_in    (COL_LOCAL_FAULT_IN),
		.fault_out    (rcv_lf)
	);

	// ----------------
	// register port and interrupt
	// ----------------
	assign wr_max_len = REG_WR_IN && (REG_ADDR_IN == OFS_MAX_LEN);
	assign wr_mask    = REG_WR_IN && (REG_ADDR_IN == OFS_IRQ_MASK);
	assign rd_status  = REG_RD_IN && (REG_ADDR_IN == OFS_IRQ_STATUS);

	// sticky event bits, rising edges for the levels
	assign irq_set[IRQ_CRC]     = |slot_bad;
	assign irq_set[IRQ_INV_CRC] = |slot_inv;
	assign irq_set[IRQ_TRUNC]   = trunc_hit;
	assign irq_set[IRQ_BIP]     = |bip_err;
	assign irq_set[IRQ_HI_BER]  = hi_ber_nxt && !hi_ber_r;
	assign irq_set[IRQ_INT_LF]  = int_lf_nxt && !int_lf_r;
	assign irq_set[IRQ_RCV_LF]  = rcv_lf && !rcv_lf_d_r;
	// a read clears, a same-cycle event still lands
	assign irq_st_nxt = (rd_status ? '0 : irq_st_r) | irq_set;

	// live status view
	assign live[LIVE_HI_BER]  = hi_ber_r;
	assign live[LIVE_INT_LF]  = int_lf_r;
	assign live[LIVE_RCV_LF]  = rcv_lf;
	assign live[LIVE_ALIGNED] = ALIGNED_IN;

	// read mux, unmapped reads give zero
	always_comb begin
		rdata_nxt = '0;
		if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				OFS_MAX_LEN:    rdata_nxt = DATA_W'(max_len_r);
				OFS_LIVE:       rdata_nxt = DATA_W'(live);
				OFS_IRQ_STATUS: rdata_nxt = DATA_W'(irq_st_r);
				OFS_IRQ_MASK:   rdata_nxt = DATA_W'(irq_mask_r);
				OFS_BER_COUNT:  rdata_nxt = DATA_W'(ber_last_r);
				default:        rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			max_len_r  <= MAX_LEN_RST;
			irq_mask_r <= IRQ_MASK_RST;
			irq_st_r   <= '0;
			irq_r      <= 1'b0;
			rdata_r    <= '0;
		end else begin
			max_len_r  <= wr_max_len ? REG_WDATA_IN[MAXLEN_W-1:0] : max_len_r;
			irq_mask_r <= wr_mask ? REG_WDATA_IN[IRQ_W-1:0] : irq_mask_r;
			irq_st_r   <= irq_st_nxt;
			irq_r      <= |(irq_st_nxt & irq_mask_r);
			rdata_r    <= rdata_nxt;
		end
	end

	// ----------------
	// outputs
	// ----------------
	assign REG_RDATA_OUT             = rdata_r;
	assign IRQ_OUT                   = irq_r;
	assign RX_LANE_MAP_ID_OUT        = map_id_r;
	assign RX_LANE_MARKER_LOCKED_OUT = lock_r;
	assign RX_CRC_ERROR_COUNT_OUT    = crc_cnt_r;
	assign RX_INVERTED_CRC_COUNT_OUT = inv_cnt_r;
	assign RX_TRUNCATED_OUT          = trunc_r;
	assign RX_BIP_ERROR_OUT          = bip_r;
	assign RX_ERROR_RATE_HIGH_OUT    = hi_ber_r;
	assign RX_INTERNAL_FAULT_OUT     = int_lf_r;
	assign RX_RECEIVED_FAULT_OUT     = rcv_lf;

endmodule

//--- rps_rx_status_monitor.sv
// port checks for the receive lane and frame status block
// assumes binding onto rps_rx_status with its single receive clock
`timescale 1ns/1ps

module rps_rx_status_monitor import rps_pkg::*; (
	// clock and reset
	input wire logic                                CLK_IN,
	input wire logic                                RST_N_IN,
	// lanes
	input wire logic [NUM_LANES-1:0]                RX_LANE_SYNC_IN,
	input wire logic [NUM_LANES-1:0]                MARKER_STB_IN,
	input wire logic [NUM_LANES-1:0][LANE_ID_W-1:0] MARKER_ID_IN,
	input wire logic [NUM_LANES-1:0][LANE_ID_W-1:0] RX_LANE_MAP_ID_OUT,
	input wire logic [NUM_LANES-1:0]                RX_LANE_MARKER_LOCKED_OUT,
	// frames
	input wire logic [SLOTS-1:0]                    EOP_SLOT_IN,
	input wire logic [SLOTS-1:0][CRC_W-1:0]         CRC_CALC_IN,
	input wire logic [SLOTS-1:0][CRC_W-1:0]         CRC_RCVD_IN,
	input wire logic                                SOP_IN,
	input wire logic [CNT_W-1:0]                    RX_CRC_ERROR_COUNT_OUT,
	input wire logic [CNT_W-1:0]                    RX_INVERTED_CRC_COUNT_OUT,
	input wire logic                                RX_TRUNCATED_OUT,
	// bip and faults
	input wire logic [NUM_LANES-1:0]                BIP_STB_IN,
	input wire logic [NUM_LANES-1:0][BIP_W-1:0]     BIP_CALC_IN,
	input wire logic [NUM_LANES-1:0][BIP_W-1:0]     BIP_RCVD_IN,
	input wire logic [NUM_LANES-1:0]                RX_BIP_ERROR_OUT,
	input wire logic                                ALIGNED_IN,
	input wire logic                                COL_VALID_IN,
	input wire logic                                COL_LOCAL_FAULT_IN,
	input wire logic                                RX_INTERNAL_FAULT_OUT,
	input wire logic                                RX_RECEIVED_FAULT_OUT
);
	// reference crc counts and bip mismatches from this cycle's inputs
	logic [CNT_W-1:0]     bad_n;
	logic [CNT_W-1:0]     inv_n;
	logic [NUM_LANES-1:0] bip_bad;
	always_comb begin
		bad_n = '0;
		inv_n = '0;
		for (int i = 0; i < SLOTS; i++) begin
			if (EOP_SLOT_IN[i] && CRC_RCVD_IN[i] == ~CRC_CALC_IN[i])
				inv_n = inv_n + 1'b1;
			else if (EOP_SLOT_IN[i] && CRC_RCVD_IN[i] != CRC_CALC_IN[i])
				bad_n = bad_n + 1'b1;
		end
		for (int l = 0; l < NUM_LANES; l++)
			bip_bad[l] = BIP_STB_IN[l] && BIP_CALC_IN[l] != BIP_RCVD_IN[l];
	end

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	// crc counts and bip pulses follow their inputs one cycle later; then truncation, lock and fault checks
	crc_count_a: assert property (RX_CRC_ERROR_COUNT_OUT == $past(bad_n))
		else $error("bad crc count");
	inv_count_a: assert property (RX_INVERTED_CRC_COUNT_OUT == $past(inv_n))
		else $error("inverted crc count");
	bip_pulse_a: assert property (RX_BIP_ERROR_OUT == $past(bip_bad))
		else $error("bip error pulses");
	trunc_once_a: assert property (RX_TRUNCATED_OUT |=> !RX_TRUNCATED_OUT || $past(SOP_IN))
		else $error("truncation repeated");
	lock_drop_a: assert property (RX_LANE_SYNC_IN == '0 |=> RX_LANE_MARKER_LOCKED_OUT == '0)
		else $error("lock without sync");
	int_fault_a: assert property (!ALIGNED_IN |=> RX_INTERNAL_FAULT_OUT)
		else $error("internal fault low");
	rcv_set_a: assert property ($rose(RX_RECEIVED_FAULT_OUT)
			|-> $past(COL_VALID_IN && COL_LOCAL_FAULT_IN))
		else $error("received fault rose early");
	rcv_clear_a: assert property ($fell(RX_RECEIVED_FAULT_OUT)
			|-> $past(COL_VALID_IN && !COL_LOCAL_FAULT_IN))
		else $error("received fault fell early");

	// captured lane id follows each accepted marker
	for (genvar l = 0; l < NUM_LANES; l++) begin : g_map
		map_hold_a: assert property ($past(MARKER_STB_IN[l] && RX_LANE_SYNC_IN[l])
				|-> RX_LANE_MAP_ID_OUT[l] == $past(MARKER_ID_IN[l]))
			else $error("lane id not captured");
	end
endmodule

bind rps_rx_status rps_rx_status_monitor u_mon (.*);

//--- rps_link_model.sv
// behavioural link partner: lane markers, sync headers, fault columns
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps

module rps_link_model import rps_pkg::*; (
	// clock
	input  wire logic                                clk_in,
	// lane markers
	output logic      [NUM_LANES-1:0]                sync_out,
	output logic      [NUM_LANES-1:0]                mstb_out,
	output logic      [NUM_LANES-1:0][LANE_ID_W-1:0] mid_out,
	// sync headers and columns
	output logic                                     sh_valid_out,
	output logic                                     sh_error_out,
	output logic                                     col_valid_out,
	output logic                                     col_lf_out
);
	// quiet link at time zero
	initial begin
		sync_out      = '0;
		mstb_out      = '0;
		mid_out       = '1;
		sh_valid_out  = 1'b0;
		sh_error_out  = 1'b0;
		col_valid_out = 1'b0;
		col_lf_out    = 1'b0;
	end

	// lock all lanes, physical lane l carrying pcs lane 19-l
	task automatic lanes_up();
		logic [NUM_LANES-1:0][LANE_ID_W-1:0] ids;
		for (int l = 0; l < NUM_LANES; l++)
			ids[l] = LANE_ID_W'(NUM_LANES - 1 - l);
		sync_out <= '1;
		mstb_out <= '1;
		mid_out  <= ids;
		@(posedge clk_in);
		mstb_out <= '0;
		mid_out  <= ~ids; // id lines no longer hold the marker
	endtask

	// lose sync on one physical lane
	task automatic lane_down(input int l);
		sync_out <= sync_out & ~(NUM_LANES'(1) << l);
	endtask

	// n headers in error, good headers afterwards
	task automatic sh_errors(input int n);
		sh_valid_out <= 1'b1;
		sh_error_out <= 1'b1;
		repeat (n) @(posedge clk_in);
		sh_error_out <= 1'b0;
	endtask

	// n valid columns, fault sequence or idle
	task automatic columns(input int n, input logic lf);
		col_valid_out <= 1'b1;
		col_lf_out    <= lf;
		repeat (n) @(posedge clk_in);
		col_valid_out <= 1'b0;
		col_lf_out    <= ~lf;
	endtask
endmodule

//--- tb.sv
// self-checking bench for the receive lane and frame status block
// assumes rps_link_model on the lane side and the bound monitor
`timescale 1ns/1ps

`define CHK(got, exp) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("unexpected at %0t: got %h expected %h", $time, got, exp); \
	end \
end

module tb import rps_pkg::*;;
	// ----------------
	// stimulus and observation
	// ----------------
	logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic sop = 1'b0, aligned = 1'b1, tpat = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [SLOTS-1:0] eop = '0;
	logic [SLOTS-1:0][CRC_W-1:0] calc = '0, rcvd = '0;
	logic [BYTES_W-1:0] bytes = '0;
	logic [NUM_LANES-1:0] bstb = '0;
	logic [NUM_LANES-1:0][BIP_W-1:0] bcalc = '0, brcvd = '0;
	wire logic [DATA_W-1:0] rdata;
	wire logic irq, trunc, hi, intf, rcvf, shv, she, colv, collf;
	wire logic [NUM_LANES-1:0] lock, bip_err, sync, mstb;
	wire logic [NUM_LANES-1:0][LANE_ID_W-1:0] map_id, mid;
	wire logic [CNT_W-1:0] crc_cnt, inv_cnt;
	int fail_count = 0, total_checks = 0, cycles = 0;

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	rps_link_model link (.clk_in(clk), .sync_out(sync), .mstb_out(mstb), .mid_out(mid),
		.sh_valid_out(shv), .sh_error_out(she), .col_valid_out(colv), .col_lf_out(collf));

	rps_rx_status DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
		.IRQ_OUT(irq), .RX_LANE_SYNC_IN(sync), .MARKER_STB_IN(mstb), .MARKER_ID_IN(mid),
		.RX_LANE_MAP_ID_OUT(map_id), .RX_LANE_MARKER_LOCKED_OUT(lock), .EOP_SLOT_IN(eop),
		.CRC_CALC_IN(calc), .CRC_RCVD_IN(rcvd), .SOP_IN(sop), .BYTES_IN(bytes),
		.RX_CRC_ERROR_COUNT_OUT(crc_cnt), .RX_INVERTED_CRC_COUNT_OUT(inv_cnt),
		.RX_TRUNCATED_OUT(trunc), .BIP_STB_IN(bstb), .BIP_CALC_IN(bcalc),
		.BIP_RCVD_IN(brcvd), .RX_BIP_ERROR_OUT(bip_err), .SH_VALID_IN(shv),
		.SH_ERROR_IN(she), .ALIGNED_IN(aligned), .TX_TEST_PATTERN_IN(tpat),
		.COL_VALID_IN(colv), .COL_LOCAL_FAULT_IN(collf), .RX_ERROR_RATE_HIGH_OUT(hi),
		.RX_INTERNAL_FAULT_OUT(intf), .RX_RECEIVED_FAULT_OUT(rcvf));

	// ----------------
	// register port and timing helpers
	// ----------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 `CHK(rdata, e)
	endtask

	// wait n edges, then let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard: the tests need about 7000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			fail_count++;
			wrap_up();
		end
	end

	// ----------------
	// test sequence
	// ----------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		link.sh_errors(97);
		tick(2);
		`CHK(hi, 1'b1)
		`CHK(intf, 1'b1)
		tick(3200);
		rd_chk(OFS_BER_COUNT, 32'h61);
		rd_chk(OFS_LIVE, 32'hb);
		rd_chk(OFS_IRQ_STATUS, 32'h30);
		tick(3200);
		`CHK(hi, 1'b0)
		`CHK(intf, 1'b0)
		rd_chk(OFS_MAX_LEN, 32'h2580);
		rd_chk(OFS_IRQ_MASK, 32'h0);
		rd_chk(8'h14, 32'h0);
		wr(OFS_LIVE, '1);
		rd_chk(OFS_LIVE, 32'h8);
		// lane map and marker lock
		@(posedge clk);
		link.lanes_up();
		tick(1);
		for (int l = 0; l < NUM_LANES; l++)
			`CHK(map_id[l], LANE_ID_W'(NUM_LANES - 1 - l))
		`CHK(lock, 20'hfffff)
		@(posedge clk);
		link.lane_down(0);
		tick(3);
		`CHK(lock, 20'h7ffff)
		// crc counts, back to back
		@(posedge clk);
		calc <= {32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111};
		rcvd <= {32'h4444bbbb, 32'hcccccccc, 32'h22222223, 32'h11111111};
		eop  <= 4'hf;
		@(posedge clk);
		eop  <= 4'h4;
		#1 `CHK(crc_cnt, 4'h2)
		`CHK(inv_cnt, 4'h1)
		@(posedge clk);
		eop  <= '0;
		#1 `CHK(crc_cnt, 4'h0)
		`CHK(inv_cnt, 4'h1)
		tick(1);
		`CHK(inv_cnt, 4'h0)
		`CHK(irq, 1'b0)
		wr(OFS_IRQ_MASK, 32'h1);
		tick(2);
		`CHK(irq, 1'b1)
		rd_chk(OFS_IRQ_STATUS, 32'h3);
		tick(2);
		`CHK(irq, 1'b0)
		// bip pulses on lanes 0 and 19, lane 1 clean
		@(posedge clk);
		brcvd <= {8'h80, 144'h0, 8'h01};
		bstb  <= 20'h80003;
		@(posedge clk);
		bstb  <= 20'h80000;
		#1 `CHK(bip_err, 20'h80001)
		@(posedge clk);
		bstb  <= '0;
		#1 `CHK(bip_err, 20'h80000)
		tick(1);
		`CHK(bip_err, 20'h00000)
		// truncation at a limit of 100 bytes
		wr(OFS_MAX_LEN, 32'd100);
		@(posedge clk);
		sop   <= 1'b1;
		bytes <= 7'd64;
		@(posedge clk);
		sop   <= 1'b0;
		tick(1);
		`CHK(trunc, 1'b1)
		@(posedge clk);
		eop   <= 4'h1;
		bytes <= '0;
		#1 `CHK(trunc, 1'b0)
		@(posedge clk);
		eop   <= '0;
		// internal fault from alignment and test pattern
		aligned <= 1'b0;
		tick(2);
		`CHK(intf, 1'b1)
		@(posedge clk);
		aligned <= 1'b1;
		tick(2);
		`CHK(intf, 1'b0)
		@(posedge clk);
		tpat <= 1'b1;
		tick(6);
		`CHK(intf, 1'b1)
		@(posedge clk);
		tpat <= 1'b0;
		tick(6);
		`CHK(intf, 1'b0)
		// received fault: set on the fourth column, clear on the 128th idle
		@(posedge clk);
		link.columns(3, 1'b1);
		#1 `CHK(rcvf, 1'b0)
		@(posedge clk);
		link.columns(1, 1'b1);
		#1 `CHK(rcvf, 1'b1)
		@(posedge clk);
		link.columns(127, 1'b0);
		#1 `CHK(rcvf, 1'b1)
		@(posedge clk);
		link.columns(1, 1'b0);
		#1 `CHK(rcvf, 1'b0)
		rd_chk(OFS_IRQ_STATUS, 32'h6c);
		wrap_up();
	end
endmodule
